//--- hdl/ugpfc_map.svh
// register indices, field positions, reset values and pin numbers of the pin function block
// included by the design modules by bare name; the package does not include it
`ifndef UGPFC_MAP_SVH
`define UGPFC_MAP_SVH

// register indices; byte address is four times the index
`define UGPFC_IDX_DELAY 10'h00b
`define UGPFC_IDX_FUNC 10'h00c
`define UGPFC_IDX_DIR 10'h00d
`define UGPFC_IDX_SET 10'h00e
`define UGPFC_IDX_CLR 10'h00f
`define UGPFC_IDX_STATUS 10'h01f

// reset values
`define UGPFC_RST_DELAY 4'h0
`define UGPFC_RST_FUNC 10'h300
`define UGPFC_RST_DIR 10'h000
`define UGPFC_RST_OUT 10'h000

// pin_function_select field positions
`define UGPFC_F_RX_TOGGLE 9
`define UGPFC_F_TX_TOGGLE 8
`define UGPFC_F_CLK_EN 7
`define UGPFC_F_P7_HI 6
`define UGPFC_F_P7_LO 5
`define UGPFC_F_P7_SEL 4
`define UGPFC_F_POL 3
`define UGPFC_F_MODEM_HI 2
`define UGPFC_F_MODEM_LO 0

// status register field position of the internal driver enable
`define UGPFC_S_DRV_EN 15

// pin numbers of the alternate functions
`define UGPFC_PIN_DTR 2
`define UGPFC_PIN_DSR 3
`define UGPFC_PIN_CTS 4
`define UGPFC_PIN_FIVE 5
`define UGPFC_PIN_SIX 6
`define UGPFC_PIN_SEVEN 7
`define UGPFC_PIN_EIGHT 8
`define UGPFC_PIN_NINE 9

`endif

//--- hdl/ugpfc_pkg.sv
// types shared by the pin function block and its turn-around counter
// does not include ugpfc_map.svh; the design modules include it themselves
package ugpfc_pkg;

    typedef enum logic [2:0] {
        UGPFC_MODEM_GPIO = 3'b000,
        UGPFC_MODEM_RTS_CTS = 3'b001,
        UGPFC_MODEM_DTR_DSR = 3'b010,
        UGPFC_MODEM_EN_SEND = 3'b011,
        UGPFC_MODEM_EN_MATCH = 3'b100
    } ugpfc_modem_t;

    typedef enum logic [1:0] {
        UGPFC_P7_GPIO = 2'b00,
        UGPFC_P7_EN_SEND = 2'b01,
        UGPFC_P7_EN_MATCH = 2'b10
    } ugpfc_p7_t;

    // signals from the serial port logic, same clock
    typedef struct packed {
        logic tx_busy;
        logic bit_tick;
        logic tx_toggle;
        logic rx_toggle;
        logic addr_match;
        logic rts;
        logic dtr;
        logic clk_out;
    } ugpfc_uart_t;

    // flow control levels handed back to the serial port
    typedef struct packed {
        logic cts;
        logic dsr;
    } ugpfc_flow_t;

    typedef struct packed {
        logic busy_prev;
        logic hold;
        logic [3:0] cnt;
        logic active;
    } ugpfc_ta_state_t;

    typedef struct packed {
        logic [3:0] delay;
        logic [9:0] func;
        logic [9:0] dir;
        logic [9:0] latch;
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic [9:0] pin_out;
        logic [9:0] pin_oe;
        logic drv_en;
        logic cts;
        logic dsr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ugpfc_state_t;

endpackage

//--- hdl/ugpfc_turnaround.sv
// transceiver turn-around counter: holds the send enable for a number of bit periods
// assumes bit_tick is a one-cycle pulse per bit time and tx_busy covers the last stop bit
`timescale 1ns/1ps
`include "ugpfc_map.svh"

module ugpfc_turnaround
    import ugpfc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // serial port side
    input wire logic tx_busy,
    input wire logic bit_tick,
    input wire logic [3:0] delay,
    // enable while sending, including the tail
    output logic active
);

    ugpfc_ta_state_t q, d;

    always_comb
    begin
        d = q;
        d.busy_prev = tx_busy;
        if (tx_busy)
        begin
            d.hold = 1'b0;
            d.cnt = 4'h0;
        end
        else if (q.busy_prev && delay != 4'h0)
        begin
            // counting starts after the final stop bit has gone out
            d.hold = 1'b1; // R1 R2
            d.cnt = delay;
        end
        else if (q.hold && bit_tick)
        begin
            if (q.cnt == 4'h1)
            begin
                d.hold = 1'b0; // R1
            end
            d.cnt = q.cnt - 4'h1;
        end
        d.active = tx_busy | d.hold;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign active = q.active;

endmodule

//--- hdl/ugpfc_top.sv
// pin function and general purpose i/o control of one serial channel, apb slave
// assumes the serial port logic on pclk supplies activity levels and a bit-time tick
`timescale 1ns/1ps
`include "ugpfc_map.svh"

// Contract
// R1 - wait programmed bit times before releasing driver
// R2 - count bit periods after last stop bit
// R3 - mode bit 9 selects receive toggle on pin nine
// R4 - mode bit 8 selects transmit toggle on pin eight
// R5 - mode bit 7 puts clock on pin six
// R6 - field 6:5 selects pin seven enable role
// R7 - bit 4 moves enable to pin seven
// R8 - software keeps pin five function distinct
// R9 - bit 3 sets driver enable polarity
// R10 - field 2:0 assigns modem flow pins
// R11 - field 2:0 codes make pin five enable
// R12 - software avoids reserved mode codes
// R13 - direction bit one drives the pin
// R14 - alternate pins ignore direction bits
// R15 - set register drives ones high
// R16 - clear register drives ones low
// R17 - input pins stay undriven after set or clear
// R18 - alternate pins ignore set and clear
// R19 - software writes zeros to reserved bits
// R20 - software pairs flow mode with pin mode
module ugpfc_top
    import ugpfc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial port side
    input wire ugpfc_uart_t uart,
    output ugpfc_flow_t flow,
    // pins
    input wire logic [9:0] pin_in,
    output logic [9:0] pin_out,
    output logic [9:0] pin_oe
);

    ugpfc_state_t q, d;
    logic ta_active;
    logic [9:0] alt;
    logic [9:0] alt_val;
    logic [9:0] alt_oe;
    logic [9:0] idx;
    logic mapped;
    logic access;
    logic en_raw;
    logic en_pin;
    logic [2:0] modem;
    logic [1:0] p7;

    ugpfc_turnaround u_turnaround (
        .pclk(pclk),
        .presetn(presetn),
        .tx_busy(uart.tx_busy),
        .bit_tick(uart.bit_tick),
        .delay(q.delay),
        .active(ta_active)
    );

    assign idx = paddr[11:2];
    assign modem = q.func[`UGPFC_F_MODEM_HI:`UGPFC_F_MODEM_LO];
    assign p7 = q.func[`UGPFC_F_P7_HI:`UGPFC_F_P7_LO];
    assign access = psel && penable && q.pready;

    // alternate function map; reserved codes fall back to plain i/o
    always_comb
    begin
        alt = 10'h000;
        alt_val = 10'h000;
        alt_oe = 10'h000;
        en_raw = 1'b0;
        if (q.func[`UGPFC_F_P7_SEL])
        begin
            if (p7 == UGPFC_P7_EN_SEND)
            begin
                en_raw = ta_active; // R6 R7
            end
            else if (p7 == UGPFC_P7_EN_MATCH)
            begin
                en_raw = uart.addr_match; // R6 R7
            end
        end
        else
        begin
            if (modem == UGPFC_MODEM_EN_SEND)
            begin
                en_raw = ta_active; // R11 R7
            end
            else if (modem == UGPFC_MODEM_EN_MATCH)
            begin
                en_raw = uart.addr_match; // R11 R7
            end
        end
        // driver enable polarity
        en_pin = q.func[`UGPFC_F_POL] ? en_raw : ~en_raw; // R9
        if (q.func[`UGPFC_F_RX_TOGGLE])
        begin
            alt[`UGPFC_PIN_NINE] = 1'b1; // R3
            alt_val[`UGPFC_PIN_NINE] = uart.rx_toggle;
            alt_oe[`UGPFC_PIN_NINE] = 1'b1;
        end
        if (q.func[`UGPFC_F_TX_TOGGLE])
        begin
            alt[`UGPFC_PIN_EIGHT] = 1'b1; // R4
            alt_val[`UGPFC_PIN_EIGHT] = uart.tx_toggle;
            alt_oe[`UGPFC_PIN_EIGHT] = 1'b1;
        end
        if (q.func[`UGPFC_F_CLK_EN])
        begin
            alt[`UGPFC_PIN_SIX] = 1'b1; // R5
            alt_val[`UGPFC_PIN_SIX] = uart.clk_out;
            alt_oe[`UGPFC_PIN_SIX] = 1'b1;
        end
        if (q.func[`UGPFC_F_P7_SEL] && (p7 == UGPFC_P7_EN_SEND || p7 == UGPFC_P7_EN_MATCH))
        begin
            alt[`UGPFC_PIN_SEVEN] = 1'b1; // R6 R7
            alt_val[`UGPFC_PIN_SEVEN] = en_pin;
            alt_oe[`UGPFC_PIN_SEVEN] = 1'b1;
        end
        case (modem)
            UGPFC_MODEM_RTS_CTS:
            begin
                alt[`UGPFC_PIN_CTS] = 1'b1; // R10
                alt[`UGPFC_PIN_FIVE] = 1'b1;
                alt_val[`UGPFC_PIN_FIVE] = uart.rts;
                alt_oe[`UGPFC_PIN_FIVE] = 1'b1;
            end
            UGPFC_MODEM_DTR_DSR:
            begin
                alt[`UGPFC_PIN_DSR] = 1'b1; // R10
                alt[`UGPFC_PIN_DTR] = 1'b1;
                alt_val[`UGPFC_PIN_DTR] = uart.dtr;
                alt_oe[`UGPFC_PIN_DTR] = 1'b1;
            end
            UGPFC_MODEM_EN_SEND, UGPFC_MODEM_EN_MATCH:
            begin
                // with the enable moved to pin seven, pin five is left to plain i/o
                if (!q.func[`UGPFC_F_P7_SEL])
                begin
                    alt[`UGPFC_PIN_FIVE] = 1'b1; // R11 R7
                    alt_val[`UGPFC_PIN_FIVE] = en_pin;
                    alt_oe[`UGPFC_PIN_FIVE] = 1'b1;
                end
            end
            default:
            begin
                alt = alt;
            end
        endcase
    end

    always_comb
    begin
        d = q;
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        d.cts = q.sync2[`UGPFC_PIN_CTS];
        d.dsr = q.sync2[`UGPFC_PIN_DSR];
        d.drv_en = en_raw;
        mapped = 1'b0;
        if (paddr[1:0] != 2'b00)
        begin
            mapped = 1'b0;
        end
        else if (idx == `UGPFC_IDX_DELAY || idx == `UGPFC_IDX_FUNC || idx == `UGPFC_IDX_DIR)
        begin
            mapped = 1'b1;
        end
        else if (idx == `UGPFC_IDX_SET || idx == `UGPFC_IDX_CLR || idx == `UGPFC_IDX_STATUS)
        begin
            mapped = 1'b1;
        end
        // one wait-free access phase; answer prepared in the setup cycle
        d.pready = psel && !penable;
        if (psel && !penable)
        begin
            d.pslverr = !mapped;
            d.prdata = 32'h0000_0000;
            if (pwrite || !mapped)
            begin
                d.prdata = 32'h0000_0000;
            end
            else if (idx == `UGPFC_IDX_DELAY)
            begin
                d.prdata = {28'h000_0000, q.delay};
            end
            else if (idx == `UGPFC_IDX_FUNC)
            begin
                d.prdata = {22'h00_0000, q.func};
            end
            else if (idx == `UGPFC_IDX_DIR)
            begin
                d.prdata = {22'h00_0000, q.dir};
            end
            else if (idx == `UGPFC_IDX_STATUS)
            begin
                d.prdata = {16'h0000, q.drv_en, 5'h00, q.sync2};
            end
        end
        else if (access)
        begin
            d.pslverr = 1'b0;
            d.prdata = 32'h0000_0000;
        end
        if (access && pwrite && mapped)
        begin
            if (idx == `UGPFC_IDX_DELAY)
            begin
                d.delay = pwdata[3:0];
            end
            else if (idx == `UGPFC_IDX_FUNC)
            begin
                d.func = pwdata[9:0];
            end
            else if (idx == `UGPFC_IDX_DIR)
            begin
                d.dir = pwdata[9:0];
            end
            else if (idx == `UGPFC_IDX_SET)
            begin
                // inputs keep the level latched but undriven; alternate pins untouched
                d.latch = q.latch | (pwdata[9:0] & ~alt); // R15 R17 R18
            end
            else if (idx == `UGPFC_IDX_CLR)
            begin
                d.latch = q.latch & ~(pwdata[9:0] & ~alt); // R16 R17 R18
            end
        end
        // alternate pins follow their function, not the direction bits
        d.pin_oe = (alt & alt_oe) | (~alt & q.dir); // R13 R14 R17
        d.pin_out = (alt & alt_val) | (~alt & q.latch); // R15 R16 R18
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.delay <= `UGPFC_RST_DELAY;
            q.func <= `UGPFC_RST_FUNC; // R3 R4
            q.dir <= `UGPFC_RST_DIR;
            q.latch <= `UGPFC_RST_OUT;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign pin_out = q.pin_out;
    assign pin_oe = q.pin_oe;
    assign flow.cts = q.cts;
    assign flow.dsr = q.dsr;

endmodule

//--- tb/ugpfc_asserts.sv
// checker of the pin function block ports
// assumes apb stores at the access edge and pins follow one edge later
`timescale 1ns/1ps
module ugpfc_asserts
    import ugpfc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // clock and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial side and pins
    input wire ugpfc_uart_t uart,
    input wire ugpfc_flow_t flow,
    input wire logic [9:0] pin_in,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe
);
    logic [9:0] f_q;
    logic [9:0] d_q;
    logic [3:0] t_q;
    logic st;
    logic snd5;
    logic wr_sc;
    // shadows, so pin roles are judged from what software wrote
    assign st = psel && penable && pready && pwrite;
    assign snd5 = !f_q[4] && f_q[2:0] == 3'h3;
    assign wr_sc = st && paddr[11:3] == 9'h007;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            f_q <= 10'h300;
            d_q <= 10'h000;
            t_q <= 4'h0;
        end
        else if (st)
        begin
            if (paddr == 12'h030)
                f_q <= pwdata[9:0];
            if (paddr == 12'h034)
                d_q <= pwdata[9:0];
            if (paddr == 12'h02c)
                t_q <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_fall;
        $fell(uart.tx_busy) && snd5 && t_q > 4'h1;
    endsequence
    property p_tog;
        (f_q[9:8] == 2'h3 && presetn) [*2] |-> pin_oe[9:8] == 2'h3
            && pin_out[9:8] == $past({uart.rx_toggle, uart.tx_toggle});
    endproperty
    a_tog: assert property (p_tog) else $error("toggle pins wrong");
    property p_clk;
        f_q[7] [*2] |-> pin_oe[6] && pin_out[6] == $past(uart.clk_out);
    endproperty
    a_clk: assert property (p_clk) else $error("clock pin wrong");
    property p_match7;
        (f_q[6:4] == 3'h5) [*2] |-> pin_oe[7] && pin_out[7] == ($past(uart.addr_match) ^ !f_q[3]);
    endproperty
    a_match7: assert property (p_match7) else $error("pin seven enable wrong");
    property p_send;
        (uart.tx_busy && snd5) [*3] |-> pin_oe[5] && pin_out[5] == f_q[3];
    endproperty
    a_send: assert property (p_send) else $error("pin five enable wrong");
    property p_hold;
        s_fall |=> (pin_out[5] == f_q[3]) [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("enable dropped early");
    property p_rts;
        (f_q[2:0] == 3'h1) [*2] |-> pin_oe[5:4] == 2'h2 && pin_out[5] == $past(uart.rts);
    endproperty
    a_rts: assert property (p_rts) else $error("flow pins wrong");
    property p_dir;
        $past(presetn) |-> pin_oe[1:0] == $past(d_q[1:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");
    property p_sc;
        wr_sc |-> ##2 (pin_oe & ~$past(pin_oe, 2)) == 10'h000;
    endproperty
    a_sc: assert property (p_sc) else $error("set or clear enabled a pin");
endmodule

//--- tb/ugpfc_xcvr.sv
// board side of the pins: resolves each wire from both drivers
// assumes drive_en marks the pins the bench pulls
`timescale 1ns/1ps
module ugpfc_xcvr
(
    // pins
    input wire logic pclk,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] drive,
    input wire logic [9:0] drive_en,
    output logic [9:0] pin_in
);
    // a floating pin keeps flipping so its level is never trusted
    logic [9:0] float_q = 10'h155;
    always_ff @(posedge pclk)
        float_q <= ~float_q;
    assign pin_in = pin_oe & pin_out | ~pin_oe & (drive_en & drive | ~drive_en & float_q);
endmodule

//--- tb/tb_uart_gpio_pin_function_control.sv
// bench of the pin function block over apb
// assumes the checker and the pin model are compiled first
`timescale 1ns/1ps
module tb_uart_gpio_pin_function_control
    import ugpfc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ugpfc_uart_t uart = '0;
    ugpfc_flow_t flow;
    logic [9:0] pin_in;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] ext = 10'h000;
    logic [9:0] ext_en = 10'h000;
    logic [2:0] tk = 3'h0;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int n_compared = 0;
    ugpfc_top #(.ADDR_W(12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .uart, .flow, .pin_in, .pin_out, .pin_oe);
    ugpfc_xcvr xcvr_u (.pclk, .pin_out, .pin_oe, .drive(ext), .drive_en(ext_en), .pin_in);
    always #50 pclk = ~pclk;
    // bit tick every 8 cycles keeps the longest hold near 120 cycles
    always @(posedge pclk)
    begin
        tk <= tk + 3'h1;
        uart.bit_tick <= tk == 3'h7;
        uart.clk_out <= tk[1];
        uart.rx_toggle <= tk[2];
        uart.tx_toggle <= tk[0];
    end
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h030, 32'h0);
        chk(rd, 32'h300);
        apb(1'b0, 12'h034, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h02c, 32'h5);
        apb(1'b0, 12'h02c, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, 12'h038, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h044, 32'h0);
        chk(32'(er), 32'h1);
    endtask
    task automatic t_gpio();
        logic [3:0] v;
        apb(1'b1, 12'h030, 32'h0);
        apb(1'b1, 12'h034, 32'h0f0);
        apb(1'b1, 12'h038, 32'h3ff);
        cyc(2);
        chk(32'(pin_oe), 32'h0f0);
        chk(32'(pin_out & pin_oe), 32'h0f0);
        apb(1'b1, 12'h03c, 32'h030);
        cyc(2);
        chk(32'(pin_out & pin_oe), 32'h0c0);
        apb(1'b1, 12'h034, 32'h3ff);
        cyc(2);
        chk(32'(pin_out), 32'h3cf);
        // latch of pin six is high, so only the clock function can make it toggle
        apb(1'b1, 12'h030, 32'h080);
        cyc(2);
        v = 4'h0;
        repeat (4)
        begin
            v = {v[2:0], pin_out[6]};
            @(posedge pclk);
        end
        chk(32'(v == 4'h3 || v == 4'h6 || v == 4'hc || v == 4'h9), 32'h1);
        chk(32'(pin_oe[6]), 32'h1);
    endtask
    task automatic t_alt();
        apb(1'b1, 12'h030, 32'h001);
        uart.rts <= 1'b1;
        ext_en <= 10'h018;
        ext <= 10'h010;
        apb(1'b1, 12'h03c, 32'h3ff);
        cyc(4);
        chk(32'({pin_out[5], pin_oe[5:4], flow.cts}), 32'hd);
        apb(1'b1, 12'h030, 32'h002);
        uart.dtr <= 1'b1;
        ext <= 10'h008;
        cyc(4);
        chk(32'({pin_out[2], pin_oe[3:2], flow.dsr}), 32'hb);
    endtask
    task automatic t_seven();
        apb(1'b1, 12'h030, 32'h031);
        uart.tx_busy <= 1'b1;
        cyc(5);
        chk(32'({pin_out[7], pin_oe[7]}), 32'h1);
        uart.tx_busy <= 1'b0;
        apb(1'b1, 12'h030, 32'h059);
        uart.addr_match <= 1'b1;
        cyc(3);
        chk(32'(pin_out[7]), 32'h1);
        apb(1'b1, 12'h030, 32'h048);
        cyc(2);
        chk(32'({pin_out[7], pin_oe[7]}), 32'h1);
        uart.addr_match <= 1'b0;
    endtask
    task automatic t_turn(input int d);
        int n;
        apb(1'b1, 12'h02c, 32'(d));
        apb(1'b1, 12'h030, 32'h00b);
        uart.tx_busy <= 1'b1;
        cyc(20);
        chk(32'(pin_out[5]), 32'h1);
        uart.tx_busy <= 1'b0;
        n = 0;
        @(posedge pclk);
        while (pin_out[5] === 1'b1 && n < 200)
        begin
            n++;
            @(posedge pclk);
        end
        chk(32'(n >= 8 * d - 8 && n <= 8 * d + 4), 32'h1);
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_gpio();
        t_alt();
        t_seven();
        t_turn(0);
        t_turn(1);
        t_turn(15);
        give_verdict();
    end
    initial
    begin
        #2000000;
        error_cnt++;
        give_verdict();
    end
endmodule
bind ugpfc_top ugpfc_asserts #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .uart, .flow, .pin_in, .pin_out,
    .pin_oe);
